/* File: logic/cbu_branch_unit.sv */
// Conditional branch unit: tests status flags and redirects the PC.
// Assumes decode holds a request until ready, and flags come from the
// status register on the same core clock.
`timescale 1ns/1ps
`default_nettype none

module cbu_branch_unit
	import cbu_pkg::*;
#(
	parameter int PcWidth = CBU_PC_W
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Request from decode
	input wire logic reqValid,
	input wire cbu_req_t req,
	output logic reqReady,
	// Status flags, read only
	input wire cbu_flags_t flags,
	// Program counter side
	output logic pcLoad,
	output logic [PcWidth-1:0] pcTarget,
	// Completion
	output logic done,
	output logic taken,
	output logic flagWrite
);

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CBU_ST_IDLE = 2'h0,
		CBU_ST_REDIRECT = 2'h1
	} cbu_state_t;

	cbu_state_t state_q;
	cbu_state_t state_d;
	logic ready_q;
	logic ready_d;
	logic pcLoad_q;
	logic pcLoad_d;
	logic done_q;
	logic done_d;
	logic taken_q;
	logic taken_d;
	logic flagWrite_q;

	// ------------------------------------------------------------
	// Condition test
	// ------------------------------------------------------------
	function automatic logic condHolds(
		input cbu_op_t op,
		input cbu_flags_t f
	);
		logic signedLess;
		signedLess = f.negative ^ f.overflow;
		unique case (op)
			CBU_OP_CARRY_CLEAR: return ~f.carry;
			CBU_OP_SAME_OR_HIGHER: return ~f.carry;
			CBU_OP_UNSIGNED_LOWER: return f.carry;
			CBU_OP_NEGATIVE: return f.negative;
			CBU_OP_POSITIVE: return ~f.negative;
			CBU_OP_SIGNED_GE: return ~signedLess;
			CBU_OP_SIGNED_LT: return signedLess;
			default: return 1'b0;
		endcase
	endfunction : condHolds

	// Accept and decision wires
	wire logic accept;
	wire logic condTrue;
	wire logic jump;
	assign accept = reqValid & ready_q;
	assign condTrue = condHolds(req.op, flags);
	assign jump = accept & condTrue;

	// ------------------------------------------------------------
	// Target address
	// ------------------------------------------------------------
	// Target is captured on the same edge as the load pulse
	cbu_target_adder #(
		.PcWidth(PcWidth)
	) u_adder (
		.clock(clock),
		.rst(rst),
		.load(jump),
		.pc(req.pc),
		.offset(req.offset),
		.target(pcTarget)
	);

	// ------------------------------------------------------------
	// Next state and outputs
	// ------------------------------------------------------------
	// Not taken: done next edge; taken: load, then done one edge later
	always_comb
	begin
		state_d = state_q;
		ready_d = ready_q;
		pcLoad_d = 1'b0;
		done_d = 1'b0;
		taken_d = 1'b0;
		unique case (state_q)
			CBU_ST_IDLE:
			begin
				if (jump)
				begin
					state_d = CBU_ST_REDIRECT;
					ready_d = 1'b0;
					pcLoad_d = 1'b1;
				end
				else if (accept)
				begin
					done_d = 1'b1;
				end
			end
			CBU_ST_REDIRECT:
			begin
				state_d = CBU_ST_IDLE;
				ready_d = 1'b1;
				done_d = 1'b1;
				taken_d = 1'b1;
			end
			default:
			begin
				state_d = CBU_ST_IDLE;
				ready_d = 1'b1;
			end
		endcase
	end

	// State and output registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q <= CBU_ST_IDLE;
			ready_q <= 1'b1;
			pcLoad_q <= 1'b0;
			done_q <= 1'b0;
			taken_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= ready_d;
			pcLoad_q <= pcLoad_d;
			done_q <= done_d;
			taken_q <= taken_d;
		end
	end

	// Branches never write the status register
	always_ff @(posedge clock)
	begin
		flagWrite_q <= 1'b0;
	end

	assign reqReady = ready_q;
	assign pcLoad = pcLoad_q;
	assign done = done_q;
	assign taken = taken_q;
	assign flagWrite = flagWrite_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cbuClk @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_CARRY_CLEAR: assert property (
		accept && req.op == CBU_OP_CARRY_CLEAR
		|=> pcLoad == !$past(flags.carry)
		&& (!pcLoad || pcTarget == cbuTarget($past(req.pc),
			$past(req.offset))))
		else $error("carry-clear branch decision or target wrong");

	AST_SAME_HIGHER: assert property (
		accept && req.op == CBU_OP_SAME_OR_HIGHER && !flags.carry
		|=> pcLoad ##1 done && taken)
		else $error("same-or-higher branch not taken on clear carry");

	AST_UNSIGNED_LOWER: assert property (
		accept && req.op == CBU_OP_UNSIGNED_LOWER
		|=> pcLoad == $past(flags.carry))
		else $error("unsigned-lower branch decision wrong");

	AST_NEGATIVE: assert property (
		accept && req.op == CBU_OP_NEGATIVE && !flags.negative
		|=> done && !pcLoad && !taken)
		else $error("minus branch taken with negative clear");

	AST_POSITIVE: assert property (
		accept && req.op == CBU_OP_POSITIVE
		|=> pcLoad == !$past(flags.negative))
		else $error("plus branch decision wrong");

	AST_SIGNED_GE: assert property (
		accept && req.op == CBU_OP_SIGNED_GE
		|=> pcLoad == !($past(flags.negative) ^ $past(flags.overflow)))
		else $error("signed greater-or-equal decision wrong");

	AST_SIGNED_LT: assert property (
		accept && req.op == CBU_OP_SIGNED_LT
		&& (flags.negative ^ flags.overflow)
		|=> pcLoad && !reqReady ##1 done && reqReady)
		else $error("signed less-than branch not taken");

	AST_NOT_TAKEN_ONE: assert property (
		accept && !condTrue |=> done && !taken && reqReady)
		else $error("not-taken branch did not finish in one cycle");

	AST_TAKEN_TWO: assert property (
		accept && condTrue |=> !done [*1] ##1 done && taken)
		else $error("taken branch did not finish in two cycles");

	AST_TARGET_HELD: assert property (
		pcLoad |=> $stable(pcTarget))
		else $error("target changed before branch completed");

	AST_NO_FLAG_WRITE: assert property (
		done |-> !flagWrite && $past(!flagWrite))
		else $error("branch wrote the status flags");

endmodule : cbu_branch_unit

`default_nettype wire

/* File: common/cbu_pkg.sv */
// Shared types, constants and helpers of the conditional branch unit.
// Assumes a single core clock and a synchronous active-high core reset.
//
// What this block does
// - Carry-clear branch jumps to PC+k+1 when carry is 0; flags untouched.
// - Same-or-higher branch is taken exactly when carry is 0.
// - Unsigned-lower branch is taken exactly when carry is 1.
// - Minus branch is taken exactly when negative is 1.
// - Plus branch is taken exactly when negative is 0.
// - Signed greater-or-equal branch is taken when negative XOR overflow is 0.
// - Signed less-than branch is taken when negative XOR overflow is 1.

package cbu_pkg;

	// ------------------------------------------------------------
	// Widths and constants
	// ------------------------------------------------------------
	localparam int CBU_PC_W = 16;
	localparam int CBU_OFS_W = 7;
	localparam logic [CBU_PC_W-1:0] CBU_TARGET_STEP = 16'h0001;
	localparam logic [CBU_PC_W-1:0] CBU_PC_RESET = 16'h0000;
	localparam int CBU_CYCLES_NOT_TAKEN = 1;
	localparam int CBU_CYCLES_TAKEN = 2;

	// ------------------------------------------------------------
	// Branch operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CBU_OP_CARRY_CLEAR = 3'h0,
		CBU_OP_SAME_OR_HIGHER = 3'h1,
		CBU_OP_UNSIGNED_LOWER = 3'h2,
		CBU_OP_NEGATIVE = 3'h3,
		CBU_OP_POSITIVE = 3'h4,
		CBU_OP_SIGNED_GE = 3'h5,
		CBU_OP_SIGNED_LT = 3'h6
	} cbu_op_t;

	// Status flags seen by the branch test
	typedef struct packed {
		logic carry;
		logic negative;
		logic overflow;
	} cbu_flags_t;

	// One branch request from decode
	typedef struct packed {
		cbu_op_t op;
		logic [CBU_OFS_W-1:0] offset;
		logic [CBU_PC_W-1:0] pc;
	} cbu_req_t;

	// Target address: PC plus sign-extended offset plus one
	function automatic logic [CBU_PC_W-1:0] cbuTarget(
		input logic [CBU_PC_W-1:0] pc,
		input logic [CBU_OFS_W-1:0] offset
	);
		logic [CBU_PC_W-1:0] ext;
		ext = {{(CBU_PC_W-CBU_OFS_W){offset[CBU_OFS_W-1]}}, offset};
		return pc + ext + CBU_TARGET_STEP;
	endfunction : cbuTarget

endpackage : cbu_pkg

/* File: logic/cbu_target_adder.sv */
// Registered branch target adder of the conditional branch unit.
// Assumes the caller pulses load only for a taken branch.
`timescale 1ns/1ps
`default_nettype none

module cbu_target_adder
	import cbu_pkg::*;
#(
	parameter int PcWidth = CBU_PC_W
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Operands
	input wire logic load,
	input wire logic [PcWidth-1:0] pc,
	input wire logic [CBU_OFS_W-1:0] offset,
	// Result
	output logic [PcWidth-1:0] target
);

	logic [PcWidth-1:0] target_q;
	logic [PcWidth-1:0] target_d;

	// Next target, held when no load
	assign target_d = load ? cbuTarget(pc, offset) : target_q;

	// Target register
	always_ff @(posedge clock)
	begin
		if (rst)
			target_q <= CBU_PC_RESET;
		else
			target_q <= target_d;
	end

	assign target = target_q;

endmodule : cbu_target_adder

`default_nettype wire

/* File: verif/cbu_pc_model.sv */
// Program counter model at the far side of the branch unit.
// Assumes pcLoad and done come from the unit on the same core clock.
`timescale 1ns/1ps
`default_nettype none

module cbu_pc_model
	import cbu_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Unit answers
	input wire logic pcLoad,
	input wire logic done,
	input wire logic taken,
	input wire logic [CBU_PC_W-1:0] pcTarget,
	// Model state
	output logic [CBU_PC_W-1:0] pcNow_q
);
	// Redirect on load, step on a not-taken finish
	always_ff @(posedge clock)
	begin
		if (rst)
			pcNow_q <= CBU_PC_RESET;
		else if (pcLoad)
			pcNow_q <= pcTarget;
		else if (done && !taken)
			pcNow_q <= pcNow_q + CBU_TARGET_STEP;
	end
endmodule : cbu_pc_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench of the branch unit with a PC model beside it.
// Assumes the unit is idle and ready between branches.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import cbu_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic reqValid = 1'b0;
	cbu_req_t req = '0;
	cbu_flags_t flags = '0;
	logic reqReady, pcLoad, done, taken, flagWrite;
	logic [CBU_PC_W-1:0] pcTarget, pcNow_q;
	int n_fail = 0;
	int n_tests = 0;

	// Core clock, 5 ns period
	always #2.5 clock = ~clock;

	cbu_branch_unit u_dut (.clock(clock), .rst(rst), .reqValid(reqValid),
		.req(req), .reqReady(reqReady), .flags(flags), .pcLoad(pcLoad),
		.pcTarget(pcTarget), .done(done), .taken(taken),
		.flagWrite(flagWrite));
	cbu_pc_model u_pc (.clock(clock), .rst(rst), .pcLoad(pcLoad),
		.done(done), .taken(taken), .pcTarget(pcTarget), .pcNow_q(pcNow_q));

	// Compare one word
	task automatic checkWord(input logic [CBU_PC_W-1:0] got,
		input logic [CBU_PC_W-1:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : checkWord

	// Verdict and end of run
	task automatic results;
		$display("tests %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Expected branch decision
	function automatic logic expTaken(input cbu_op_t op, input cbu_flags_t f);
		case (op)
			CBU_OP_CARRY_CLEAR, CBU_OP_SAME_OR_HIGHER: return !f.carry;
			CBU_OP_UNSIGNED_LOWER: return f.carry;
			CBU_OP_NEGATIVE: return f.negative;
			CBU_OP_POSITIVE: return !f.negative;
			CBU_OP_SIGNED_GE: return !(f.negative ^ f.overflow);
			CBU_OP_SIGNED_LT: return f.negative ^ f.overflow;
			default: return 1'b0;
		endcase
	endfunction : expTaken

	// Issue one branch and judge answer, timing and new PC
	task automatic runBranch(input cbu_op_t op, input cbu_flags_t f,
		input logic [CBU_OFS_W-1:0] k);
		logic exp;
		logic [CBU_PC_W-1:0] pc0, tgt;
		int n;
		int nLoad;
		@(negedge clock);
		pc0 = pcNow_q;
		exp = expTaken(op, f);
		tgt = pc0 + {{(CBU_PC_W-CBU_OFS_W){k[CBU_OFS_W-1]}}, k} + 16'h0001;
		flags = f;
		req = '{op: op, offset: k, pc: pc0};
		reqValid = 1'b1;
		@(negedge clock);
		reqValid = 1'b0;
		flags = ~f;
		n = 1;
		nLoad = 0;
		while (done !== 1'b1 && n < 4)
		begin
			if (pcLoad === 1'b1)
				nLoad = n;
			checkWord(16'(reqReady), 16'(!(exp && n == 1)), "ready");
			@(negedge clock);
			n++;
		end
		if (done !== 1'b1)
		begin
			n_fail++;
			results();
		end
		checkWord(16'(n), exp ? 16'h0002 : 16'h0001, "cycles");
		checkWord(16'(nLoad), 16'(exp), "load");
		checkWord(16'(taken), 16'(exp), "taken");
		checkWord(16'(flagWrite), 16'h0000, "flags");
		checkWord(16'(pcLoad), 16'h0000, "load at done");
		checkWord(16'(reqReady), 16'h0001, "ready at done");
		@(negedge clock);
		checkWord(16'(done), 16'h0000, "done");
		checkWord(pcNow_q, exp ? tgt : pc0 + 16'h0001, "pc");
		if (exp)
			checkWord(pcTarget, tgt, "target");
	endtask : runBranch

	// Outputs held at rest while in reset
	task automatic scnReset;
		checkWord(16'({reqReady, pcLoad, done, taken, flagWrite}),
			16'h0010, "reset outputs");
		checkWord(pcTarget, 16'h0000, "reset target");
	endtask : scnReset

	// Every op against every flag pattern, offsets of both signs
	task automatic scnAllOps;
		for (int op = 0; op < 7; op++)
			for (int f = 0; f < 8; f++)
				runBranch(cbu_op_t'(op[2:0]), cbu_flags_t'(f[2:0]),
					7'({op[2:0], f[2:0], 1'b1}));
	endtask : scnAllOps

	// Largest forward and backward offsets, and the unused code
	task automatic scnEdges;
		runBranch(CBU_OP_CARRY_CLEAR, 3'h0, 7'h3F);
		runBranch(CBU_OP_SIGNED_LT, 3'h2, 7'h40);
		runBranch(cbu_op_t'(3'h7), 3'h7, 7'h05);
	endtask : scnEdges

	initial
	begin
		repeat (12) @(posedge clock);
		@(negedge clock);
		scnReset();
		rst = 1'b0;
		scnAllOps();
		scnEdges();
		results();
	end
endmodule : testbench
`default_nettype wire
